/* rtl/sgc_global_ctrl.sv */
// Global control registers 0x06-0x0a of a three port switch
// Assumes strap pins stable during reset, plain register port
//
// Function
// - Repeater bit enables repeater, resets 0
// - Duplex bit one gives MII half
// - Duplex zero full; reset from strap
// - Flow bit enables pause; strap reset
// - Speed bit one 10M; strap reset
// - Null VID replaced when bit set
// - Eleven bit threshold split across registers
// - Period 67 ms or 500 ms
// - Threshold resets to 0x63
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "sgc_cfg.svh"
module sgc_global_ctrl
    import sgc_pkg::*;
#(
    parameter int unsigned PORTS   = 3,
    parameter int unsigned CYC_100 = `SGC_CYC_100,
    parameter int unsigned CYC_10  = `SGC_CYC_10
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    input  wire logic [7:0]       i_addr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [7:0]       o_rdata,
    input  wire logic             i_duplex_strap_pin,
    input  wire logic             i_flow_control_strap_pin,
    input  wire logic             i_speed_strap_pin,
    input  wire logic [PORTS-1:0] i_storm_block,
    output logic      [PORTS-1:0] o_storm_drop,
    output sgc_cfg_t              o_cfg
);
    initial begin
        if (CYC_100 >= CYC_10)
            $error("10M period must exceed 100M period");
    end

    // ======================================================
    // Register state
    typedef struct packed {
        logic       in_rst;
        logic [7:0] mode;
        logic [7:0] rate_lo;
        logic [7:0] test0;
        logic [7:0] test1;
        logic [7:0] test2;
        logic [7:0] rdata;
        sgc_cfg_t   cfg;
    } sgc_regs_t;

    sgc_regs_t st;
    sgc_regs_t next_st;
    sgc_req_t  req;
    logic      restart;
    logic [PORTS-1:0] drop;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Read decode, unmapped offsets return zero
    function automatic logic [7:0] rd_mux(input sgc_regs_t s,
                                          input logic [7:0] a);
        unique case (a)
            `SGC_OFF_MODE:    rd_mux = s.mode;
            `SGC_OFF_RATE_LO: rd_mux = s.rate_lo;
            `SGC_OFF_TEST0:   rd_mux = s.test0;
            `SGC_OFF_TEST1:   rd_mux = s.test1;
            `SGC_OFF_TEST2:   rd_mux = s.test2;
            default:          rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    // ======================================================
    // Next state: straps captured in the first enabled cycle after release
    always_comb begin
        next_st = st;
        next_st.in_rst = 1'b0;
        if (st.in_rst) begin
            // Clocked capture; async reset may not load pin values
            next_st.mode[`SGC_BIT_HALF_DUP] = i_duplex_strap_pin;
            next_st.mode[`SGC_BIT_FLOW_CTL] =
                i_flow_control_strap_pin;
            next_st.mode[`SGC_BIT_SPEED_10] = i_speed_strap_pin;
        end else if (req.wr) begin
            // Factory test registers stay writable, like the rest
            unique case (req.addr)
                `SGC_OFF_MODE:    next_st.mode    = req.wdata;
                `SGC_OFF_RATE_LO: next_st.rate_lo = req.wdata;
                `SGC_OFF_TEST0:   next_st.test0   = req.wdata;
                `SGC_OFF_TEST1:   next_st.test1   = req.wdata;
                `SGC_OFF_TEST2:   next_st.test2   = req.wdata;
                default:          next_st.test0   = st.test0;
            endcase
        end
        next_st.rdata = req.rd ? rd_mux(st, req.addr) : 8'h00;
        // Decoded settings registered for the core
        next_st.cfg.repeater_en      = next_st.mode[`SGC_BIT_REPEATER];
        next_st.cfg.mii_half_duplex  =
            next_st.mode[`SGC_BIT_HALF_DUP];
        next_st.cfg.mii_flow_ctl     = next_st.mode[`SGC_BIT_FLOW_CTL];
        next_st.cfg.mii_speed_10     = next_st.mode[`SGC_BIT_SPEED_10];
        next_st.cfg.null_vid_replace =
            next_st.mode[`SGC_BIT_NULL_VID];
        next_st.cfg.storm_rate = {next_st.mode[2:0], next_st.rate_lo};
    end

    // ======================================================
    // Registers; reset loads constants only
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st         <= '0;
            st.in_rst  <= 1'b1;
            st.mode    <= {5'h00, `SGC_RST_RATE_HI};
            st.rate_lo <= `SGC_RST_RATE_LO;
            st.test0   <= `SGC_RST_TEST0;
            st.test1   <= `SGC_RST_TEST1;
            st.test2   <= `SGC_RST_TEST2;
            st.cfg.storm_rate <= {`SGC_RST_RATE_HI, `SGC_RST_RATE_LO};
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ======================================================
    // Storm period and per-port metering
    sgc_period_timer #(
        .CYC_100 (CYC_100),
        .CYC_10  (CYC_10)
    ) u_timer (
        .i_clk_sys  (i_clk_sys),
        .i_sys_rst  (i_sys_rst),
        .i_ce       (i_ce),
        .i_speed_10 (st.cfg.mii_speed_10),
        .o_restart  (restart)
    );

    sgc_storm_meter #(
        .PORTS (PORTS)
    ) u_meter (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_restart (restart),
        .i_rate    (st.cfg.storm_rate),
        .i_block   (i_storm_block),
        .o_drop    (drop)
    );

    assign o_storm_drop = drop;
    assign o_rdata      = st.rdata;
    assign o_cfg        = st.cfg;

    // ======================================================
    // Checks
    a_rst_rate: assert property (@(posedge i_clk_sys)
        $past(i_sys_rst) |-> o_cfg.storm_rate == 11'h063)
        else $error("threshold reset wrong");

    a_rst_repeat: assert property (@(posedge i_clk_sys)
        $past(i_sys_rst) |-> !o_cfg.repeater_en
            && !o_cfg.null_vid_replace)
        else $error("repeater or vid reset wrong");

    a_strap_dup: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        $past(i_sys_rst) && i_ce |=>
            o_cfg.mii_half_duplex == $past(i_duplex_strap_pin))
        else $error("duplex strap not captured");

    a_strap_flow: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        $past(i_sys_rst) && i_ce |=>
            o_cfg.mii_flow_ctl == $past(i_flow_control_strap_pin))
        else $error("flow strap not captured");

    a_strap_spd: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        $past(i_sys_rst) && i_ce |=>
            o_cfg.mii_speed_10 == $past(i_speed_strap_pin))
        else $error("speed strap not captured");

    a_write_mode: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !st.in_rst && i_wr && i_addr == 8'h06 |=>
            o_cfg.repeater_en == $past(i_wdata[7])
            && o_cfg.mii_half_duplex == $past(i_wdata[6])
            && o_cfg.null_vid_replace == $past(i_wdata[3]))
        else $error("mode write not applied");

    a_write_rate: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !st.in_rst && i_wr && i_addr == 8'h07 |=>
            o_cfg.storm_rate[7:0] == $past(i_wdata))
        else $error("rate write not applied");

    a_read_back: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && i_rd && i_addr == 8'h07 |=>
            o_rdata == $past(st.rate_lo))
        else $error("read data wrong");

    // Upper threshold bits and the remaining mode fields
    a_write_hi: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !st.in_rst && i_wr && i_addr == `SGC_OFF_MODE |=>
            o_cfg.storm_rate[10:8] == $past(i_wdata[2:0]))
        else $error("rate high write not applied");

    a_write_fs: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !st.in_rst && i_wr && i_addr == `SGC_OFF_MODE |=>
            o_cfg.mii_flow_ctl == $past(i_wdata[`SGC_BIT_FLOW_CTL])
            && o_cfg.mii_speed_10 == $past(i_wdata[`SGC_BIT_SPEED_10]))
        else $error("flow or speed write not applied");

    // Settings other than the strapped bits hold unless their own register is written
    a_rate_keep: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !(i_wr && i_addr == `SGC_OFF_RATE_LO) |=>
            $stable(o_cfg.storm_rate[7:0]))
        else $error("rate low changed without write");

    a_mode_keep: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !(i_wr && i_addr == `SGC_OFF_MODE) |=>
            $stable(o_cfg.repeater_en) && $stable(o_cfg.null_vid_replace))
        else $error("mode bit changed without write");

    // A write in the strap capture cycle is refused
    a_strap_no_wr: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && st.in_rst |=>
            $stable(o_cfg.storm_rate) && $stable(o_cfg.repeater_en))
        else $error("write taken during strap capture");

    a_write_test: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !st.in_rst && i_wr && i_addr == `SGC_OFF_TEST1 |=>
            st.test1 == $past(i_wdata))
        else $error("test register write not applied");

    // ======================================================
    // Read port checks: data stands one cycle, zero otherwise
    a_rdata_idle: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && !i_rd |=> o_rdata == 8'h00)
        else $error("read data not cleared");

    a_read_mode: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && i_rd && i_addr == `SGC_OFF_MODE |=>
            o_rdata == $past(st.mode))
        else $error("mode read wrong");

    a_read_test0: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && i_rd && i_addr == `SGC_OFF_TEST0 |=>
            o_rdata == $past(st.test0))
        else $error("first test read wrong");

    a_read_test1: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && i_rd && i_addr == `SGC_OFF_TEST1 |=>
            o_rdata == $past(st.test1))
        else $error("second test read wrong");

    a_read_test2: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && i_rd && i_addr == `SGC_OFF_TEST2 |=>
            o_rdata == $past(st.test2))
        else $error("third test read wrong");

    a_read_unmapped: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && i_rd && (i_addr < `SGC_OFF_MODE || i_addr > `SGC_OFF_TEST2)
            |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");

    // ======================================================
    // Reset values and clock enable freeze
    a_rst_tests: assert property (@(posedge i_clk_sys)
        $past(i_sys_rst) |-> st.test0 == `SGC_RST_TEST0
            && st.test1 == `SGC_RST_TEST1 && st.test2 == `SGC_RST_TEST2)
        else $error("test register reset wrong");

    a_rst_outputs: assert property (@(posedge i_clk_sys)
        $past(i_sys_rst) |-> o_rdata == 8'h00 && o_storm_drop == '0)
        else $error("read data or drop reset wrong");

    // Frozen enable must hold every register, straps included
    a_ce_freeze: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        !i_ce |=> $stable(st))
        else $error("state moved with enable low");
endmodule : sgc_global_ctrl

/* rtl/sgc_cfg.svh */
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from design files
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH
// ==========================================================
// Register offsets
`define SGC_OFF_MODE       8'h06
`define SGC_OFF_RATE_LO    8'h07
`define SGC_OFF_TEST0      8'h08
`define SGC_OFF_TEST1      8'h09
`define SGC_OFF_TEST2      8'h0a
// ==========================================================
// Field positions in port_mode_and_storm_rate_high
`define SGC_BIT_REPEATER   7
`define SGC_BIT_HALF_DUP   6
`define SGC_BIT_FLOW_CTL   5
`define SGC_BIT_SPEED_10   4
`define SGC_BIT_NULL_VID   3
// ==========================================================
// Reset values
`define SGC_RST_RATE_HI    3'h0
`define SGC_RST_RATE_LO    8'h63
`define SGC_RST_TEST0      8'h00
`define SGC_RST_TEST1      8'h24
`define SGC_RST_TEST2      8'h35
// ==========================================================
// Storm period timing
`define SGC_CLK_MHZ        250
`define SGC_PERIOD_100_MS  67
`define SGC_PERIOD_10_MS   500
`define SGC_CYC_100 (`SGC_PERIOD_100_MS * 1000 * `SGC_CLK_MHZ)
`define SGC_CYC_10  (`SGC_PERIOD_10_MS * 1000 * `SGC_CLK_MHZ)
`define SGC_BLOCK_BYTES    64
`endif

/* rtl/sgc_pkg.sv */
// Types shared by the global control bank and its helpers
// Assumes the cfg header for numeric constants
package sgc_pkg;
    // ======================================================
    // Decoded configuration carried to the switch core
    typedef struct packed {
        logic        repeater_en;
        logic        mii_half_duplex;
        logic        mii_flow_ctl;
        logic        mii_speed_10;
        logic        null_vid_replace;
        logic [10:0] storm_rate;
    } sgc_cfg_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sgc_req_t;
endpackage : sgc_pkg

/* rtl/sgc_period_timer.sv */
// Storm measurement period timer, one restart pulse per period
// Assumes a free running system clock with enable
`timescale 1ns/1ns
module sgc_period_timer
    import sgc_pkg::*;
#(
    parameter int unsigned CYC_100 = 16750000,
    parameter int unsigned CYC_10  = 125000000
) (
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    input  wire logic i_ce,
    input  wire logic i_speed_10,
    output logic      o_restart
);
    initial begin
        if (CYC_100 < 2 || CYC_10 < 2)
            $error("period counts too small");
    end

    typedef struct packed {
        logic [31:0] cnt;
        logic        pulse;
    } sgc_tmr_t;

    sgc_tmr_t st;
    sgc_tmr_t next_st;
    logic [31:0] limit;

    // ======================================================
    // Period length follows port speed
    always_comb begin
        limit   = i_speed_10 ? CYC_10 - 1 : CYC_100 - 1;
        next_st = st;
        next_st.pulse = 1'b0;
        if (st.cnt >= limit) begin
            next_st.cnt   = 32'h0;
            next_st.pulse = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 32'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst)
            st <= '0;
        else if (i_ce)
            st <= next_st;
    end

    assign o_restart = st.pulse;

    a_period_pulse: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && st.cnt >= limit |=> st.pulse)
        else $error("period restart missing");
endmodule : sgc_period_timer

/* rtl/sgc_storm_meter.sv */
// Per-port broadcast block meter against the storm threshold
// Assumes one block pulse per 64 bytes of regulated traffic
`timescale 1ns/1ns
module sgc_storm_meter
    import sgc_pkg::*;
#(
    parameter int unsigned PORTS = 3
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    input  wire logic             i_restart,
    input  wire logic [10:0]      i_rate,
    input  wire logic [PORTS-1:0] i_block,
    output logic      [PORTS-1:0] o_drop
);
    initial begin
        if (PORTS < 1 || PORTS > 8)
            $error("port count out of range");
    end

    typedef struct packed {
        logic [PORTS-1:0][10:0] cnt;
        logic [PORTS-1:0]       drop;
    } sgc_mtr_t;

    sgc_mtr_t st;
    sgc_mtr_t next_st;

    // ======================================================
    // Count blocks, drop once the threshold is reached
    always_comb begin
        next_st = st;
        for (int p = 0; p < PORTS; p++) begin
            if (i_restart) begin
                // A block in the restart cycle opens the new period
                next_st.cnt[p]  = {10'h000, i_block[p]};
                next_st.drop[p] = i_block[p] && (i_rate < 11'h002);
            end else if (i_block[p] && !st.drop[p]) begin
                next_st.cnt[p] = st.cnt[p] + 11'h1;
                if (st.cnt[p] + 11'h1 >= i_rate)
                    next_st.drop[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst)
            st <= '0;
        else if (i_ce)
            st <= next_st;
    end

    assign o_drop = st.drop;

    a_drop_clear: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_ce && i_restart |=>
            o_drop == ($past(i_block) & {PORTS{$past(i_rate) < 11'h002}}))
        else $error("drop not cleared on restart");
endmodule : sgc_storm_meter

/* verif/sgc_global_ctrl_tb.sv */
// Self-checking bench for the global control register bank
// Assumes the bench drives every port itself, no partner model
`timescale 1ns/1ns
module sgc_global_ctrl_tb
    import sgc_pkg::*;
;
    // ==========================================================
    // Short storm periods keep the run brief
    localparam int C100 = 20;
    localparam int C10  = 40;

    logic       clk;
    logic       rst;
    logic       ce;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       dup;
    logic       flow;
    logic       spd;
    logic [2:0] blk;
    logic [2:0] drop;
    sgc_cfg_t   cfg;
    int         n_errors;
    int         tests_run;
    int         cyc;

    sgc_global_ctrl #(.PORTS(3), .CYC_100(C100), .CYC_10(C10)) dut_u (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_duplex_strap_pin(dup), .i_flow_control_strap_pin(flow),
        .i_speed_strap_pin(spd), .i_storm_block(blk),
        .o_storm_drop(drop), .o_cfg(cfg));

    // ==========================================================
    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [10:0] e,
                       input logic [10:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic final_report;
        $display("Checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // ==========================================================
    // Register port: one-cycle strobes, read data the cycle after
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk(nm, {3'h0, e}, {3'h0, rdata});
    endtask : rd_chk

    // Reset with chosen strap levels, then wait out strap capture
    task automatic do_reset(input logic d, input logic f, input logic s);
        @(posedge clk);
        rst  <= 1'b1;
        dup  <= d;
        flow <= f;
        spd  <= s;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset

    task automatic blocks(input int n);
        repeat (n) begin
            @(posedge clk);
            blk <= 3'b001;
            @(posedge clk);
            blk <= 3'b000;
        end
    endtask : blocks

    // Bounded wait for the port 0 drop level; gives up on a hang
    task automatic wait_drop(input logic lvl, output int t);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (drop[0] === lvl) begin
                t = cyc;
                return;
            end
        end
        n_errors++;
        $display("Error drop wait expected %b seen %b", lvl, drop[0]);
        final_report();
    endtask : wait_drop

    // Flood port 0 to find a restart; the next clear is one period on
    task automatic period(input int exp);
        int t1;
        int t2;
        @(posedge clk);
        blk <= 3'b001;
        wait_drop(1'b1, t1);
        wait_drop(1'b0, t1);
        // Restart-cycle block and the next one make two of three
        @(posedge clk);
        blk <= 3'b000;
        #1 chk("drop below rate", 11'h0, {10'h0, drop[0]});
        blocks(1);
        wait_drop(1'b1, t2);
        chk("drop quiet port", 11'h0, {8'h0, drop[2:1], 1'b0});
        wait_drop(1'b0, t2);
        chk("period", exp[10:0], 11'(t2 - t1));
    endtask : period

    // ==========================================================
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("Error watchdog expected finish seen hang");
        final_report();
    end

    // ==========================================================
    // Main sequence
    initial begin
        n_errors = 0; tests_run = 0; cyc = 0;
        rst = 1'b1; ce = 1'b1; addr = 8'h00; wdata = 8'h00;
        wr = 1'b0; rd = 1'b0; dup = 1'b0; flow = 1'b0; spd = 1'b0;
        blk = 3'b000;
        // Straps high and low on both resets, second one mid-run
        do_reset(1'b1, 1'b0, 1'b1);
        chk("cfg rate", 11'h063, cfg.storm_rate);
        chk("cfg repeater", 11'h0, {10'h0, cfg.repeater_en});
        chk("cfg null vid", 11'h0, {10'h0, cfg.null_vid_replace});
        rd_chk("mode", 8'h06, 8'h50);
        rd_chk("rate low", 8'h07, 8'h63);
        rd_chk("test0", 8'h08, 8'h00);
        rd_chk("test1", 8'h09, 8'h24);
        rd_chk("test2", 8'h0a, 8'h35);
        do_reset(1'b0, 1'b1, 1'b0);
        rd_chk("mode", 8'h06, 8'h20);
        // Each lower mode bit alone reaches its own config field
        for (int i = 3; i < 7; i++) begin
            wr_reg(8'h06, 8'(1 << i));
            #1 chk("cfg bits", 11'(1 << (i - 3)), {6'h0, cfg.repeater_en,
                cfg.mii_half_duplex, cfg.mii_flow_ctl, cfg.mii_speed_10,
                cfg.null_vid_replace});
            rd_chk("mode", 8'h06, 8'(1 << i));
        end
        // Repeater only after 100M half duplex is set up
        wr_reg(8'h06, 8'h40);
        wr_reg(8'h06, 8'hc0);
        #1 chk("cfg repeater", 11'h018, {6'h0, cfg.repeater_en,
            cfg.mii_half_duplex, cfg.mii_flow_ctl, cfg.mii_speed_10,
            cfg.null_vid_replace});
        rd_chk("mode", 8'h06, 8'hc0);
        wr_reg(8'h06, 8'h00);
        #1 chk("cfg bits", 11'h0, {6'h0, cfg.repeater_en,
            cfg.mii_half_duplex, cfg.mii_flow_ctl, cfg.mii_speed_10,
            cfg.null_vid_replace});
        // Threshold split across two registers, 0x512 and the top 0x7ff
        wr_reg(8'h06, 8'h05);
        wr_reg(8'h07, 8'h12);
        #1 chk("cfg rate", 11'h512, cfg.storm_rate);
        wr_reg(8'h06, 8'h07);
        wr_reg(8'h07, 8'hff);
        #1 chk("cfg rate", 11'h7ff, cfg.storm_rate);
        // Unmapped places read zero and ignore writes
        wr_reg(8'h0b, 8'hff);
        rd_chk("unmapped", 8'h0b, 8'h00);
        rd_chk("unmapped", 8'h05, 8'h00);
        // Frozen clock enable must not take a write
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(8'h07, 8'haa);
        ce <= 1'b1;
        rd_chk("rate frozen", 8'h07, 8'hff);
        // Storm metering at both speeds, threshold of three blocks
        wr_reg(8'h06, 8'h00);
        wr_reg(8'h07, 8'h03);
        period(C100);
        wr_reg(8'h06, 8'h10);
        period(C10);
        final_report();
    end
endmodule : sgc_global_ctrl_tb
